/* npe_pkg.sv */
/*
  shared constants and types of the nand page ecc checker: register
  offsets, field positions, reset values, watched commands and states.
  assumes nothing of its surroundings.
*/
`default_nettype none

package npe_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets on the apb port
  localparam logic [7:0] OFS_ECC_COMMAND    = 8'h00;
  localparam logic [7:0] OFS_PAGE_LENGTH    = 8'h04;
  localparam logic [7:0] OFS_ERROR_FLAGS    = 8'h08;
  localparam logic [7:0] OFS_PARITY_POS     = 8'h0C;
  localparam logic [7:0] OFS_INVERSE_PARITY = 8'h10;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int RESET_REQ_BIT    = 0;
  localparam int PAGE_LEN_LSB     = 0;
  localparam int PAGE_LEN_W       = 2;
  localparam int FLAG_CORRECTABLE = 0;
  localparam int FLAG_CODE_ERR    = 1;
  localparam int FLAG_MULTIPLE    = 2;
  localparam int FLAGS_W          = 3;
  localparam int BIT_OFS_LSB      = 0;
  localparam int BIT_OFS_W        = 4;
  localparam int WORD_OFS_LSB     = 4;
  localparam int WORD_OFS_W       = 12;
  localparam int CODE_W           = 16;

  ////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [PAGE_LEN_W-1:0] RESET_PAGE_LEN = 2'h0;
  localparam logic [FLAGS_W-1:0]    RESET_FLAGS    = 3'h0;
  localparam logic [CODE_W-1:0]     RESET_PARITY   = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // page geometry and watched flash commands
  localparam int MAIN_WORDS_BASE = 512;
  localparam int PAGE_WORDS_BASE = 528;
  localparam int INDEX_BITS_BASE = 9;
  localparam logic [7:0] CMD_PAGE_READ = 8'h00;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h80;
  localparam logic [1:0] STORED_BEATS_BYTE = 2'h3;
  localparam logic [1:0] STORED_BEATS_WIDE = 2'h1;

  typedef enum logic [2:0] {
    NPE_IDLE,
    NPE_ARMED,
    NPE_RUN,
    NPE_FETCH,
    NPE_DONE
  } npe_state_t;

endpackage

`default_nettype wire

/* npe_syndrome.sv */
/*
  syndrome decoder: compares a computed code pair with the stored pair
  and sorts the outcome into no error, correctable, code error, multiple.
  assumes inputs are stable in the cycle the caller samples the outputs.
*/
`timescale 1ns/1ps
`default_nettype none

module npe_syndrome
  import npe_pkg::*;
#(
  parameter int W = 16
) (
  // codes
  input  wire logic [W-1:0] calc_true,
  input  wire logic [W-1:0] calc_comp,
  input  wire logic [W-1:0] stored_true,
  input  wire logic [W-1:0] stored_comp,
  input  wire logic [W-1:0] active_mask,
  // outcome
  output logic [W-1:0]      syn_true,
  output logic [W-1:0]      syn_comp,
  output logic              no_error,
  output logic              correctable,
  output logic              code_error,
  output logic              multiple
);

  // refuse a code too narrow to hold a pair
  if (W < 2) begin : g_bad_width
    $error("npe_syndrome: W must be at least 2");
  end

  logic [2*W-1:0] whole;
  logic           one_hot;

  ////////////////////////////////////////////////////////////////////////
  // classification of the syndrome pair
  always_comb begin
    syn_true    = (calc_true ^ stored_true) & active_mask;
    syn_comp    = (calc_comp ^ stored_comp) & active_mask;
    whole       = {syn_true, syn_comp};
    one_hot     = (whole != '0) && ((whole & (whole - 1'b1)) == '0); // R1
    no_error    = (whole == '0);                                 // R8
    // one data bit flips exactly one of each true/complement pair
    correctable = !no_error && ((syn_true ^ syn_comp) == active_mask); // R9
    code_error  = !no_error && !correctable && one_hot;          // R10
    multiple    = !no_error && !correctable && !one_hot;         // R11
  end

endmodule

`default_nettype wire

/* npe_checker.sv */
/*
  nand page ecc checker: watches flash command, address and data strobes,
  builds a true/complement parity code per page, checks it on reads and
  shows results in five apb registers.
  assumes the strobes are one-cycle pulses synchronous to mclk.
*/
// What this block does
// R1 - correct one bit per page, detect random two-bit errors
// R2 - two-bit page length setting selects 528, 1056, 2112 or 4224 words
// R3 - start computing on page read 00h or page program 80h command
// R4 - host starts each page access exactly at a page boundary
// R5 - results valid at main-area end, frozen until the next watched command or reset request; reads change them again after the stored code words
// R6 - host software copies parity values into the spare area
// R7 - host reads main area then stored parity words consecutively
// R8 - zero syndrome reports no error, all flags clear
// R9 - single data error sets only correctable flag, word and bit offsets
// R10 - single stored-code bit error sets code error flag
// R11 - unrecoverable errors set multiple error flag
// R12 - correctable flag also set together with multiple error flag
// R13 - command detect or software reset clears status and parity registers
// R14 - writing 1 to reset request clears parity results, 0 does nothing
// R15 - per-page code of line and column parity for 512 to 4096 words
// R16 - word index bit set feeds true line parity, else complement
// R17 - word is 8 or 16 bits by organisation, offsets count words
// R18 - registers reached over an apb revision 2 slave
// R19 - after single error the parity register low field holds bit offset
// R20 - column parity from odd/even bits, pairs, nibbles, widened for 16 bit
`timescale 1ns/1ps
`default_nettype none

module npe_checker
  import npe_pkg::*;
#(
  parameter int DATA_W  = 16,
  parameter int INDEX_W = 12
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // apb revision 2 slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  // watched flash traffic
  input  wire logic        nand_cmd_strobe,
  input  wire logic        nand_addr_strobe,
  input  wire logic        nand_wr_strobe,
  input  wire logic        nand_rd_strobe,
  input  wire logic [15:0] nand_data,
  input  wire logic        bus_is_16bit
);

  // refuse widths the column and line logic cannot serve
  if (DATA_W != 16 || INDEX_W != WORD_OFS_W) begin : g_bad_params
    $error("npe_checker: DATA_W must be 16 and INDEX_W must be 12");
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  npe_state_t             state_reg, state_next;
  logic [PAGE_LEN_W-1:0]  page_len_reg, page_len_next;
  logic [FLAGS_W-1:0]     flags_reg, flags_next;
  logic [CODE_W-1:0]      parity_reg, parity_next;
  logic [CODE_W-1:0]      inverse_parity_value_reg, inverse_parity_value_next;
  logic [CODE_W-1:0]      acc_t_reg, acc_t_next;
  logic [CODE_W-1:0]      acc_c_reg, acc_c_next;
  logic [31:0]            stored_reg, stored_next;
  logic [12:0]            word_cnt_reg, word_cnt_next;
  logic [1:0]             beat_reg, beat_next;
  logic                   is_read_reg, is_read_next;
  logic [31:0]            prdata_reg, prdata_next;

  ////////////////////////////////////////////////////////////////////////
  // decode of bus and flash events
  logic              apb_wr;
  logic              sw_clear;
  logic              cmd_take;
  logic              data_take;
  logic [DATA_W-1:0] word;
  logic [12:0]       main_words;
  logic [CODE_W-1:0] active_mask;
  logic [31:0]       stored_full;
  logic              word_par;
  logic [3:0]        col_t;
  logic [3:0]        col_c;
  logic              end_of_main;
  logic              last_beat;

  assign apb_wr    = psel && penable && pwrite;                        // R18
  assign sw_clear  = apb_wr && (paddr == OFS_ECC_COMMAND)
                     && pwdata[RESET_REQ_BIT];                         // R14
  assign cmd_take  = nand_cmd_strobe && ((nand_data[7:0] == CMD_PAGE_READ)
                     || (nand_data[7:0] == CMD_PAGE_PROG));            // R3
  assign data_take = is_read_reg ? nand_rd_strobe : nand_wr_strobe;
  assign word      = bus_is_16bit ? nand_data : {8'h00, nand_data[7:0]}; // R17
  assign main_words = 13'(MAIN_WORDS_BASE) << page_len_reg;            // R2
  // line bits beyond the page's index width stay unused
  assign active_mask = {(12'hFFF >> (2'd3 - page_len_reg)),
                        (bus_is_16bit ? 4'hF : 4'h7)};                 // R15
  assign end_of_main = data_take && (word_cnt_reg == main_words - 13'd1);
  assign last_beat   = beat_reg == (bus_is_16bit ? STORED_BEATS_WIDE
                                                 : STORED_BEATS_BYTE);
  assign stored_full = bus_is_16bit ? {word, stored_reg[31:16]}
                                    : {word[7:0], stored_reg[31:8]};

  ////////////////////////////////////////////////////////////////////////
  // column parity of the current word
  always_comb begin
    word_par = ^word;
    col_t    = 4'h0;
    col_c    = 4'h0;
    for (int b = 0; b < DATA_W; b++) begin
      for (int k = 0; k < 4; k++) begin
        if (b[k]) begin
          col_t[k] = col_t[k] ^ word[b];                               // R20
        end else begin
          col_c[k] = col_c[k] ^ word[b];                               // R20
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // syndrome check of computed against stored code
  logic [CODE_W-1:0] syn_t;
  logic [CODE_W-1:0] syn_c;
  logic              no_err;
  logic              corr;
  logic              code_err;
  logic              multi;

  npe_syndrome #(
    .W (CODE_W)
  ) u_syndrome (
    .calc_true   (acc_t_reg),
    .calc_comp   (acc_c_reg),
    .stored_true (stored_full[15:0]),
    .stored_comp (stored_full[31:16]),
    .active_mask (active_mask),
    .syn_true    (syn_t),
    .syn_comp    (syn_c),
    .no_error    (no_err),
    .correctable (corr),
    .code_error  (code_err),
    .multiple    (multi)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state of the page tracker and result registers
  always_comb begin
    state_next    = state_reg;
    page_len_next = page_len_reg;
    flags_next    = flags_reg;
    parity_next   = parity_reg;
    inverse_parity_value_next  = inverse_parity_value_reg;
    acc_t_next    = acc_t_reg;
    acc_c_next    = acc_c_reg;
    stored_next   = stored_reg;
    word_cnt_next = word_cnt_reg;
    beat_next     = beat_reg;
    is_read_next  = is_read_reg;

    if (apb_wr && paddr == OFS_PAGE_LENGTH) begin
      page_len_next = pwdata[PAGE_LEN_LSB +: PAGE_LEN_W];              // R2
    end

    // reset request first, so a result landing in the same cycle wins
    if (sw_clear) begin
      flags_next   = RESET_FLAGS;                                      // R13
      parity_next  = RESET_PARITY;                                     // R14
      inverse_parity_value_next = RESET_PARITY;                                     // R14
    end

    case (state_reg)
      NPE_ARMED: begin
        // address cycles align the counter to the page start
        if (nand_addr_strobe) begin
          state_next    = NPE_RUN;                                     // R4
          word_cnt_next = 13'd0;
          acc_t_next    = RESET_PARITY;
          acc_c_next    = RESET_PARITY;
        end
      end
      NPE_RUN: begin
        if (data_take) begin
          word_cnt_next = word_cnt_reg + 13'd1;
          for (int i = 0; i < INDEX_W; i++) begin
            if (active_mask[WORD_OFS_LSB + i]) begin
              if (word_cnt_reg[i]) begin
                acc_t_next[WORD_OFS_LSB + i] =
                  acc_t_reg[WORD_OFS_LSB + i] ^ word_par;              // R16
              end else begin
                acc_c_next[WORD_OFS_LSB + i] =
                  acc_c_reg[WORD_OFS_LSB + i] ^ word_par;              // R16
              end
            end
          end
          acc_t_next[3:0] = acc_t_reg[3:0] ^ (col_t & active_mask[3:0]);
          acc_c_next[3:0] = acc_c_reg[3:0] ^ (col_c & active_mask[3:0]);
          if (end_of_main) begin
            parity_next  = acc_t_next;                                 // R5
            inverse_parity_value_next = acc_c_next;                                 // R5
            beat_next    = 2'd0;
            state_next   = is_read_reg ? NPE_FETCH : NPE_DONE;         // R6
          end
        end
      end
      NPE_FETCH: begin
        // stored parity then inverse parity follow the main area
        if (data_take) begin
          stored_next = stored_full;                                   // R7
          beat_next   = beat_reg + 2'd1;
          if (last_beat) begin
            state_next   = NPE_DONE;
            parity_next  = syn_t;                                      // R19
            inverse_parity_value_next = syn_c;                                      // R10
            flags_next   = RESET_FLAGS;                                // R8
            flags_next[FLAG_CORRECTABLE] = corr || multi;              // R12
            flags_next[FLAG_CODE_ERR]    = code_err;                   // R10
            flags_next[FLAG_MULTIPLE]    = multi;                      // R11
          end
        end
      end
      NPE_IDLE, NPE_DONE: begin
        // results stay frozen until a new start or a reset request
      end
      default: begin
        state_next = NPE_IDLE;
      end
    endcase

    if (cmd_take) begin
      state_next   = NPE_ARMED;                                        // R3
      is_read_next = (nand_data[7:0] == CMD_PAGE_READ);
      flags_next   = RESET_FLAGS;                                      // R13
      parity_next  = RESET_PARITY;                                     // R13
      inverse_parity_value_next = RESET_PARITY;                                     // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= NPE_IDLE;
      page_len_reg <= RESET_PAGE_LEN;
      flags_reg    <= RESET_FLAGS;
      parity_reg   <= RESET_PARITY;
      inverse_parity_value_reg  <= RESET_PARITY;
      acc_t_reg    <= RESET_PARITY;
      acc_c_reg    <= RESET_PARITY;
      stored_reg   <= 32'h0000_0000;
      word_cnt_reg <= 13'd0;
      beat_reg     <= 2'd0;
      is_read_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      page_len_reg <= page_len_next;
      flags_reg    <= flags_next;
      parity_reg   <= parity_next;
      inverse_parity_value_reg  <= inverse_parity_value_next;
      acc_t_reg    <= acc_t_next;
      acc_c_reg    <= acc_c_next;
      stored_reg   <= stored_next;
      word_cnt_reg <= word_cnt_next;
      beat_reg     <= beat_next;
      is_read_reg  <= is_read_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb read data, captured in the setup phase
  always_comb begin
    prdata_next = prdata_reg;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_PAGE_LENGTH:    prdata_next = {30'h0, page_len_reg};
        OFS_ERROR_FLAGS:    prdata_next = {29'h0, flags_reg};
        OFS_PARITY_POS:     prdata_next = {16'h0, parity_reg};         // R9
        OFS_INVERSE_PARITY: prdata_next = {16'h0, inverse_parity_value_reg};
        default:            prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_cmd_clears: assert property (@(posedge mclk) disable iff (sys_rst) // R13
    cmd_take |=> (flags_reg == RESET_FLAGS) && (parity_reg == RESET_PARITY)
                 && (state_reg == NPE_ARMED))
    else $error("command did not clear results and arm");

  a_sw_reset: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    (sw_clear && !(state_reg == NPE_FETCH && data_take && last_beat)
     && !(state_reg == NPE_RUN && end_of_main))
      |=> (parity_reg == RESET_PARITY) && (inverse_parity_value_reg == RESET_PARITY))
    else $error("reset request did not clear parity");

  a_zero_write: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    (apb_wr && paddr == OFS_ECC_COMMAND && !pwdata[RESET_REQ_BIT] && !cmd_take
     && state_reg == NPE_DONE) |=> $stable(parity_reg) && $stable(inverse_parity_value_reg))
    else $error("writing zero changed parity");

  a_main_end: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    (state_reg == NPE_RUN && end_of_main && !cmd_take && !sw_clear)
      |=> (parity_reg == $past(acc_t_next)) && (state_reg != NPE_RUN))
    else $error("results not valid at main area end");

  a_frozen: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    (state_reg == NPE_DONE && !cmd_take && !sw_clear)
      |=> $stable(parity_reg) && $stable(flags_reg) && state_reg == NPE_DONE)
    else $error("results changed while frozen");

  a_no_error: assert property (@(posedge mclk) disable iff (sys_rst) // R8
    (state_reg == NPE_FETCH && data_take && last_beat && no_err && !cmd_take
     && !sw_clear) |=> flags_reg == 3'h0 && parity_reg == 16'h0000)
    else $error("clean page raised a flag");

  a_single_err: assert property (@(posedge mclk) disable iff (sys_rst) // R9
    (state_reg == NPE_FETCH && data_take && last_beat && corr && !cmd_take
     && !sw_clear) |=> flags_reg == 3'h1 && parity_reg == $past(syn_t))
    else $error("single error not reported");

  a_code_err: assert property (@(posedge mclk) disable iff (sys_rst) // R10
    (state_reg == NPE_FETCH && data_take && last_beat && code_err && !cmd_take
     && !sw_clear) |=> flags_reg == 3'h2 && $onehot({parity_reg, inverse_parity_value_reg}))
    else $error("code error not reported");

  a_multi_flags: assert property (@(posedge mclk) disable iff (sys_rst) // R12
    flags_reg[FLAG_MULTIPLE] |-> flags_reg[FLAG_CORRECTABLE]
                                 && !flags_reg[FLAG_CODE_ERR])
    else $error("multiple error without correctable flag");

  a_page_len: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    main_words == 13'(MAIN_WORDS_BASE) * (13'd1 << page_len_reg)
    && (main_words + (main_words >> 5)) == 13'(PAGE_WORDS_BASE) << page_len_reg)
    else $error("page length decode wrong");

endmodule

`default_nettype wire

/* npe_flash_model.sv */
/*
  flash partner: holds one page and its stored code words and replays
  the host's command, address and data strobes on request.
  assumes a free running mclk; all strobes change on its falling edge.
*/
`timescale 1ns/1ps
`default_nettype none

module npe_flash_model (
  // clock
  input  wire logic   mclk,
  // flash traffic seen by the checker
  output logic        cmd_strobe,
  output logic        addr_strobe,
  output logic        wr_strobe,
  output logic        rd_strobe,
  output logic [15:0] data
);
  // page contents and stored code words
  logic [15:0] mem   [0:4095];
  logic [15:0] spare [0:3];

  // bus quiet at time zero
  initial begin
    cmd_strobe  = 1'b0;
    addr_strobe = 1'b0;
    wr_strobe   = 1'b0;
    rd_strobe   = 1'b0;
    data        = 16'h0000;
  end

  //////////////////////////////////////////////////////////////////////////
  // one strobe cycle driven just after a falling edge
  task automatic beat(input logic c, input logic a, input logic w, input logic r,
                      input logic [15:0] d);
    @(negedge mclk);
    cmd_strobe  = c;
    addr_strobe = a;
    wr_strobe   = w;
    rd_strobe   = r;
    data        = d;
  endtask

  // released bus shows the inverse of the last value, never a stale copy
  task automatic idle();
    beat(1'b0, 1'b0, 1'b0, 1'b0, ~data);
  endtask

  // command, address cycles, main words, then stored code words
  task automatic run(input logic [7:0] cmd, input int words, input logic wide,
                     input int nstored, input logic rd);
    logic [15:0] m;
    m = wide ? 16'hFFFF : 16'h00FF;
    beat(1'b1, 1'b0, 1'b0, 1'b0, {8'h00, cmd});
    beat(1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
    beat(1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
    for (int j = 0; j < words; j++) begin
      beat(1'b0, 1'b0, !rd, rd, mem[j] & m);
    end
    for (int k = 0; k < nstored; k++) begin
      beat(1'b0, 1'b0, 1'b0, 1'b1, spare[k] & m);
    end
    idle();
  endtask
endmodule

`default_nettype wire

/* npe_checker_tb.sv */
/*
  testbench of the nand page ecc checker: page writes at every length,
  page reads with clean, single, stored-code and double errors, clears.
  assumes the flash partner model and the design package.
*/
`timescale 1ns/1ps
`default_nettype none

module npe_checker_tb
  import npe_pkg::*;
;
  logic        mclk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        cmd_s;
  logic        addr_s;
  logic        wr_s;
  logic        rd_s;
  logic [15:0] nand_data;
  logic        bus_is_16bit;
  int          miscompares = 0;
  int          checks = 0;

  //////////////////////////////////////////////////////////////////////////
  // design and flash partner
  npe_checker #(.DATA_W(16), .INDEX_W(12)) i_npe_checker (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .nand_cmd_strobe(cmd_s), .nand_addr_strobe(addr_s), .nand_wr_strobe(wr_s),
    .nand_rd_strobe(rd_s), .nand_data(nand_data), .bus_is_16bit(bus_is_16bit)
  );

  npe_flash_model i_npe_flash_model (
    .mclk(mclk), .cmd_strobe(cmd_s), .addr_strobe(addr_s), .wr_strobe(wr_s),
    .rd_strobe(rd_s), .data(nand_data)
  );

  // 25 mhz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////
  // verdict, comparison and apb access
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb_write(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    psel   = 1'b1;
    pwrite = 1'b1;
    paddr  = a;
    pwdata = d;
    @(negedge mclk);
    penable = 1'b1;
    @(negedge mclk);
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
  endtask

  task automatic expect_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    @(negedge mclk);
    psel   = 1'b1;
    pwrite = 1'b0;
    paddr  = a;
    @(negedge mclk);
    penable = 1'b1;
    @(posedge mclk);
    v = prdata;
    @(negedge mclk);
    psel    = 1'b0;
    penable = 1'b0;
    check(name, exp, v);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // page pattern and reference code: {complement, true}
  task automatic fill(input int seed);
    for (int j = 0; j < 4096; j++) begin
      i_npe_flash_model.mem[j] = (16'(j) * 16'h9E37) ^ 16'(seed * 4369);
    end
  endtask

  function automatic logic [31:0] calc_code(input int size, input logic wide);
    logic [15:0] t;
    logic [15:0] c;
    logic [15:0] w;
    t = 16'h0000;
    c = 16'h0000;
    for (int j = 0; j < (512 << size); j++) begin
      w = i_npe_flash_model.mem[j] & (wide ? 16'hFFFF : 16'h00FF);
      for (int b = 0; b < 16; b++) begin
        for (int k = 0; k < (wide ? 4 : 3); k++) begin
          if (b[k]) t[k] = t[k] ^ w[b];
          else c[k] = c[k] ^ w[b];
        end
      end
      for (int i = 0; i < 9 + size; i++) begin
        if (j[i]) t[4+i] = t[4+i] ^ (^w);
        else c[4+i] = c[4+i] ^ (^w);
      end
    end
    return {c, t};
  endfunction

  // program a page, send stray write strobes, then read back its code to show it frozen
  task automatic write_case(input int size, input logic wide);
    logic [31:0] code;
    bus_is_16bit = wide;
    apb_write(OFS_PAGE_LENGTH, 32'(size));
    expect_reg("page_length", OFS_PAGE_LENGTH, 32'(size));
    fill(size);
    code = calc_code(size, wide);
    i_npe_flash_model.run(CMD_PAGE_PROG, 512 << size, wide, 0, 1'b0);
    repeat (3) i_npe_flash_model.beat(1'b0, 1'b0, 1'b1, 1'b0, 16'h5A5A);
    i_npe_flash_model.idle();
    expect_reg("parity", OFS_PARITY_POS, {16'h0000, code[15:0]});
    expect_reg("inverse", OFS_INVERSE_PARITY, {16'h0000, code[31:16]});
    expect_reg("flags", OFS_ERROR_FLAGS, 32'h0000_0000);
  endtask

  // read a page whose stored code was written back, after injecting the fault chosen by kind (none for kind 0)
  task automatic read_case(input int size, input logic wide, input int kind,
                           input int w, input int b);
    logic [31:0] code;
    logic [15:0] mask;
    logic [15:0] p;
    logic [15:0] n;
    logic [2:0]  fl;
    bus_is_16bit = wide;
    apb_write(OFS_PAGE_LENGTH, 32'(size));
    fill(kind + 7);
    code = calc_code(size, wide);
    if (wide) begin
      i_npe_flash_model.spare[0] = code[15:0];
      i_npe_flash_model.spare[1] = code[31:16];
    end else begin
      i_npe_flash_model.spare[0] = {8'h00, code[7:0]};
      i_npe_flash_model.spare[1] = {8'h00, code[15:8]};
      i_npe_flash_model.spare[2] = {8'h00, code[23:16]};
      i_npe_flash_model.spare[3] = {8'h00, code[31:24]};
    end
    mask = {12'((1 << (9 + size)) - 1), wide ? 4'hF : 4'h7};
    p = 16'h0000;
    n = 16'h0000;
    fl = 3'h0;
    case (kind)
      1: begin
        i_npe_flash_model.mem[w][b] = ~i_npe_flash_model.mem[w][b];
        p = {12'(w), 4'(b)};
        n = ~p & mask;
        fl = 3'h1;
      end
      2: begin
        i_npe_flash_model.spare[wide ? 1 : 2][b] = ~i_npe_flash_model.spare[wide ? 1 : 2][b];
        n = 16'h0001 << b;
        fl = 3'h2;
      end
      3: begin
        i_npe_flash_model.mem[w][b] = ~i_npe_flash_model.mem[w][b];
        i_npe_flash_model.mem[w+1][b] = ~i_npe_flash_model.mem[w+1][b];
        fl = 3'h5;
      end
      default: fl = 3'h0;
    endcase
    i_npe_flash_model.run(CMD_PAGE_READ, 512 << size, wide, wide ? 2 : 4, 1'b1);
    expect_reg("flags", OFS_ERROR_FLAGS, {29'h0, fl});
    if (kind != 3) begin
      expect_reg("parity", OFS_PARITY_POS, {16'h0000, p});
      expect_reg("inverse", OFS_INVERSE_PARITY, {16'h0000, n});
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    bus_is_16bit = 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    for (int a = 0; a <= 20; a += 4) begin
      expect_reg("reset value", 8'(a), 32'h0000_0000);
    end
    for (int s = 0; s < 4; s++) begin
      write_case(s, s[0]);
    end
    read_case(0, 1'b0, 0, 0, 0);
    read_case(0, 1'b0, 1, 301, 5);
    read_case(1, 1'b1, 1, 700, 12);
    read_case(0, 1'b0, 2, 0, 4);
    read_case(0, 1'b1, 2, 0, 9);
    read_case(0, 1'b0, 3, 40, 2);
    i_npe_flash_model.run(8'h30, 512, 1'b0, 0, 1'b0);
    expect_reg("flags", OFS_ERROR_FLAGS, 32'h0000_0005);
    apb_write(OFS_ERROR_FLAGS, 32'h0000_0000);
    expect_reg("flags", OFS_ERROR_FLAGS, 32'h0000_0005);
    expect_reg("command", OFS_ECC_COMMAND, 32'h0000_0000);
    read_case(0, 1'b0, 1, 17, 3);
    apb_write(OFS_ECC_COMMAND, 32'h0000_0000);
    expect_reg("parity", OFS_PARITY_POS, 32'h0000_0113);
    apb_write(OFS_ECC_COMMAND, 32'h0000_0001);
    expect_reg("parity", OFS_PARITY_POS, 32'h0000_0000);
    expect_reg("inverse", OFS_INVERSE_PARITY, 32'h0000_0000);
    expect_reg("flags", OFS_ERROR_FLAGS, 32'h0000_0000);
    read_case(0, 1'b0, 1, 511, 7);
    i_npe_flash_model.run(CMD_PAGE_PROG, 0, 1'b0, 0, 1'b0);
    expect_reg("flags", OFS_ERROR_FLAGS, 32'h0000_0000);
    expect_reg("parity", OFS_PARITY_POS, 32'h0000_0000);
    print_verdict();
  end

  // hang guard
  initial begin
    #2000000;
    miscompares++;
    print_verdict();
  end
endmodule

`default_nettype wire
